/* File: shared/dsr_pkg.sv */
// Constants and types for the disk slave response-control handler
`default_nettype none
package dsr_pkg;
   // Response-type bus control codes
   localparam logic [7:0] CMD_READ_DISK_SPEC = 8'h49;
   localparam logic [7:0] CMD_READ_PORT_CTL = 8'h4a;
   localparam logic [7:0] CMD_READ_FMT_PARAM = 8'h4b;
   localparam logic [7:0] CMD_READ_BUF_CTL = 8'h4c;
   localparam logic [7:0] CMD_READ_SLIP = 8'h4d;
   localparam logic [7:0] CMD_READ_DEFERRED = 8'h4e;
   localparam logic [7:0] CMD_READ_ROT_POS = 8'h4f;
   // Data control coding
   localparam logic [7:0] DC_STEP_HEAD = 8'h90;
   localparam int DC_IS_DATA_BIT = 7;
   localparam int DC_HEAD_ADV_BIT = 4;
   // Disk specification tail offsets
   localparam logic [7:0] OFS_ECC_COUNT = 8'h46;
   localparam logic [7:0] OFS_ZONE_COUNT = 8'h48;
   localparam logic [7:0] OFS_SPEC_DESC = 8'h4a;
   // Sizes
   localparam int ZONES = 4;
   localparam int FIELDS = 3;
   localparam int PAIR_OCTETS = 6;
   localparam int FMT_HDR_OCTETS = 6;
   localparam int ZONE_DESC_OCTETS = 10;
   localparam int GAP_DESC_OCTETS = 4;
   localparam int ROT_OCTETS = 12;
   localparam int BUF_PARAM_OCTETS = 8;
   localparam int SLIP_OCTETS = 16;
   localparam int BUF_DEPTH = 2;
   localparam logic [15:0] ZONE_OCTETS_RESET = 16'h2000;
   localparam logic [31:0] PULSE_WIDTH_RESET = 32'h0000_0040;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SEND = 4'b0010,
      ST_REJECT = 4'b0100,
      ST_DONE = 4'b1000
   } dsr_state_t;
endpackage : dsr_pkg
`default_nettype wire

/* File: logic/dsr_skid.sv */
// Two-entry valid/ready buffer for response octets
`default_nettype none
module dsr_skid
   import dsr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // Fill side
   input wire logic in_valid_in,
   input wire logic [7:0] in_data_in,
   output logic in_ready_out,
   // Drain side
   output logic out_valid_out,
   output logic [7:0] out_data_out,
   input wire logic out_ready_in
);
   typedef struct packed {
      logic [BUF_DEPTH-1:0][7:0] mem;
      logic [1:0] cnt;
   } dsr_skid_t;
   dsr_skid_t s_q, s_d;
   logic push, pop;
   assign in_ready_out = (s_q.cnt != 2'(BUF_DEPTH));
   assign out_valid_out = (s_q.cnt != 2'h0);
   assign out_data_out = s_q.mem[0];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   always_comb begin
      s_d = s_q;
      if (pop) begin
         s_d.mem[0] = s_q.mem[1];
      end
      if (push) begin
         s_d.mem[(pop ? s_q.cnt - 2'h1 : s_q.cnt) == 2'h0 ? 0 : 1] = in_data_in;
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : dsr_skid
`default_nettype wire

/* File: logic/dsr_resp.sv */
// Response-control handler of a disk slave: parameter streams, rejects, head counter
`default_nettype none
module dsr_resp
   import dsr_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // Bus control from master
   input wire logic ctl_valid_in,
   input wire logic [7:0] ctl_code_in,
   input wire logic ctl_parity_err_in,
   output logic ctl_ready_out,
   // Response octet stream
   output logic resp_valid_out,
   output logic [7:0] resp_data_out,
   input wire logic resp_ready_in,
   // Slave status
   output logic status_valid_out,
   output logic status_reject_out,
   output logic status_context_out,
   output logic status_deferred_out,
   // Data transfer end
   input wire logic xfer_end_in,
   input wire logic successful_transfer_flag_in,
   output logic [15:0] head_count_out,
   // Configuration and state
   input wire logic format_init_in,
   input wire logic buffer_mode_in,
   input wire logic buffer_only_in,
   input wire logic data_ecc_en_in,
   input wire logic header_ecc_en_in,
   input wire logic [15:0] ecc_octets_in,
   input wire logic [1:0] cur_zone_in,
   input wire logic defer_now_in,
   input wire logic power_on_reset_in,
   input wire logic alt_allegiance_explicit_in,
   input wire logic alt_allegiance_implicit_in,
   output logic irq_enable_out,
   // Parameter loads
   input wire logic port_ctl_load_in,
   input wire logic [7:0] port_ctl_explicit_in,
   input wire logic [7:0] port_ctl_implicit_in,
   input wire logic rot_load_in,
   input wire logic [95:0] rot_param_in,
   input wire logic [7:0] buf_flags_in,
   input wire logic [8*BUF_PARAM_OCTETS-1:0] buf_param_in,
   input wire logic [8*SLIP_OCTETS-1:0] slip_table_in,
   input wire logic [15:0] pre_gap_in,
   input wire logic [15:0] post_gap_in
);
   typedef struct packed {
      dsr_state_t st;
      logic [7:0] cmd;
      logic [15:0] idx;
      logic [15:0] last;
      logic [15:0] head;
      logic [7:0] pc_exp;
      logic [7:0] pc_imp;
      logic rot_user;
      logic [95:0] rot;
      logic [95:0] rot_saved;
      logic buf_mode;
      logic defer_pend;
      logic adv_pend;
      logic [7:0] defer_cmd;
      logic por_seen;
      logic st_rej;
      logic st_ctx;
      logic st_def;
   } dsr_regs_t;
   dsr_regs_t r_q, r_d;
   logic buf_in_ready;
   logic oct_valid;
   logic [7:0] oct;
   logic [7:0] eff_cmd;
   // Pick octet k of a big-endian field packed into a vector
   function automatic logic [7:0] octet_of(input logic [127:0] v, input int nbytes,
                                           input int k);
      octet_of = v[8*(nbytes-1-k) +: 8];
   endfunction : octet_of
   // Following-count octets equal last octet index minus one
   function automatic logic [15:0] follow_count(input int total);
      follow_count = 16'(total - 2);
   endfunction : follow_count
   function automatic int stream_len(input logic [7:0] c);
      case (c)
         CMD_READ_DISK_SPEC: stream_len = int'(OFS_SPEC_DESC) + ZONES * PAIR_OCTETS;
         CMD_READ_PORT_CTL: stream_len = 2;
         CMD_READ_FMT_PARAM:
            stream_len = FMT_HDR_OCTETS + ZONES * (ZONE_DESC_OCTETS + FIELDS * GAP_DESC_OCTETS);
         CMD_READ_BUF_CTL: stream_len = 4 + BUF_PARAM_OCTETS;
         CMD_READ_SLIP: stream_len = 2 + SLIP_OCTETS;
         CMD_READ_ROT_POS: stream_len = ROT_OCTETS;
         default: stream_len = 0;
      endcase
   endfunction : stream_len
   // Default pulse width scales with zone; master values stay fixed
   logic [95:0] rot_eff;
   assign rot_eff = r_q.rot_user ? r_q.rot
      : {r_q.rot[95:80], PULSE_WIDTH_RESET + 32'({cur_zone_in, 4'h0}), r_q.rot[47:0]};
   // Octet generator for the stream being sent
   always_comb begin
      int i;
      int z;
      int o;
      logic [15:0] w;
      i = int'(r_q.idx);
      oct = 8'h00;
      w = 16'h0000;
      z = 0;
      o = 0;
      eff_cmd = (r_q.cmd == CMD_READ_DEFERRED) ? r_q.defer_cmd : r_q.cmd;
      case (eff_cmd)
         CMD_READ_DISK_SPEC: begin
            if (i < 2) begin
               oct = octet_of(128'(follow_count(stream_len(eff_cmd))), 2, i);
            end else if (i >= int'(OFS_ECC_COUNT) && i < int'(OFS_ZONE_COUNT)) begin
               w = (data_ecc_en_in || header_ecc_en_in) ? ecc_octets_in : 16'h0000;
               oct = octet_of(128'(w), 2, i - int'(OFS_ECC_COUNT));
            end else if (i >= int'(OFS_ZONE_COUNT) && i < int'(OFS_SPEC_DESC)) begin
               oct = octet_of(128'(16'(ZONES)), 2, i - int'(OFS_ZONE_COUNT));
            end else if (i >= int'(OFS_SPEC_DESC)) begin
               z = (i - int'(OFS_SPEC_DESC)) / PAIR_OCTETS;
               o = (i - int'(OFS_SPEC_DESC)) % PAIR_OCTETS;
               oct = octet_of(128'({16'(z), 16'h0000, ZONE_OCTETS_RESET - 16'(z * 16)}),
                              PAIR_OCTETS, o);
            end
         end
         CMD_READ_PORT_CTL: oct = (i == 0) ? r_q.pc_exp : r_q.pc_imp;
         CMD_READ_FMT_PARAM: begin
            if (i < FMT_HDR_OCTETS) begin
               oct = octet_of(128'({follow_count(stream_len(eff_cmd)), 16'(ZONES), 16'(FIELDS)}),
                              FMT_HDR_OCTETS, i);
            end else begin
               z = (i - FMT_HDR_OCTETS) / (ZONE_DESC_OCTETS + FIELDS * GAP_DESC_OCTETS);
               o = (i - FMT_HDR_OCTETS) % (ZONE_DESC_OCTETS + FIELDS * GAP_DESC_OCTETS);
               if (o < ZONE_DESC_OCTETS) begin
                  oct = octet_of(128'({16'(z), 32'(z * 1000), 32'(z * 1000 + 999)}),
                                 ZONE_DESC_OCTETS, o);
               end else begin
                  oct = octet_of(128'({pre_gap_in, post_gap_in}), GAP_DESC_OCTETS,
                                 (o - ZONE_DESC_OCTETS) % GAP_DESC_OCTETS);
               end
            end
         end
         CMD_READ_BUF_CTL: begin
            if (i < 2) begin
               oct = octet_of(128'(follow_count(stream_len(eff_cmd))), 2, i);
            end else if (i < 4) begin
               oct = (i == 2) ? 8'h00 : buf_flags_in;
            end else begin
               oct = octet_of(128'(buf_param_in), BUF_PARAM_OCTETS, i - 4);
            end
         end
         CMD_READ_SLIP: begin
            if (i < 2) begin
               oct = octet_of(128'(follow_count(stream_len(eff_cmd))), 2, i);
            end else begin
               oct = octet_of(slip_table_in, SLIP_OCTETS, i - 2);
            end
         end
         CMD_READ_ROT_POS: oct = octet_of(128'(rot_eff), ROT_OCTETS, i);
         default: oct = 8'h00;
      endcase
   end
   assign oct_valid = (r_q.st == ST_SEND);
   assign ctl_ready_out = (r_q.st == ST_IDLE);
   assign status_valid_out = (r_q.st == ST_DONE);
   assign status_reject_out = r_q.st_rej;
   assign status_context_out = r_q.st_ctx;
   assign status_deferred_out = r_q.st_def;
   assign head_count_out = r_q.head;
   // Alternate-port allegiance masks interrupts after power-on unless disabled
   assign irq_enable_out = !(r_q.por_seen &&
      ((alt_allegiance_explicit_in && r_q.pc_exp == 8'h00) ||
       (alt_allegiance_implicit_in && r_q.pc_imp == 8'h00)));
   always_comb begin
      logic take;
      logic rej;
      logic [7:0] c;
      take = ctl_valid_in && ctl_ready_out;
      c = ctl_code_in;
      rej = 1'b0;
      r_d = r_q;
      r_d.por_seen = r_q.por_seen || power_on_reset_in;
      if (port_ctl_load_in) begin
         r_d.pc_exp = port_ctl_explicit_in;
         r_d.pc_imp = port_ctl_implicit_in;
      end
      if (rot_load_in && !buffer_mode_in) begin
         r_d.rot = rot_param_in;
         r_d.rot_user = 1'b1;
      end
      r_d.buf_mode = buffer_mode_in;
      if (buffer_mode_in && !r_q.buf_mode) begin
         r_d.rot_saved = r_q.rot;
      end
      if (!buffer_mode_in && r_q.buf_mode) begin
         r_d.rot = r_q.rot_saved;
      end
      r_d.adv_pend = r_q.adv_pend && !xfer_end_in;
      if (r_q.adv_pend && xfer_end_in && successful_transfer_flag_in && !ctl_parity_err_in) begin
         r_d.head = r_q.head + 16'h0001;
      end
      case (r_q.st)
         ST_IDLE: begin
            if (take && c[DC_IS_DATA_BIT]) begin
               r_d.defer_pend = 1'b0;
               if (buffer_mode_in && (c == DC_STEP_HEAD || c[DC_HEAD_ADV_BIT])) begin
                  rej = 1'b1;
               end else if (c == DC_STEP_HEAD && !ctl_parity_err_in) begin
                  r_d.head = r_q.head + 16'h0001;
               end
               r_d.adv_pend = !rej && c[DC_HEAD_ADV_BIT] && c != DC_STEP_HEAD;
               r_d.st_rej = rej;
               r_d.st_ctx = 1'b0;
               r_d.st_def = 1'b0;
               r_d.st = ST_DONE;
            end else if (take) begin
               r_d.cmd = c;
               r_d.idx = 16'h0000;
               r_d.defer_pend = 1'b0;
               rej = (c == CMD_READ_FMT_PARAM && !format_init_in) ||
                  (c == CMD_READ_DEFERRED && !r_q.defer_pend) ||
                  (c == CMD_READ_ROT_POS && (buffer_mode_in || buffer_only_in)) ||
                  (c != CMD_READ_DEFERRED && stream_len(c) == 0);
               r_d.st_rej = rej;
               r_d.st_ctx = rej && (c == CMD_READ_FMT_PARAM || c == CMD_READ_DEFERRED);
               r_d.st_def = 1'b0;
               if (rej) begin
                  r_d.st = ST_DONE;
               end else if (defer_now_in && c != CMD_READ_DEFERRED) begin
                  r_d.defer_pend = 1'b1;
                  r_d.defer_cmd = c;
                  r_d.st_def = 1'b1;
                  r_d.st = ST_DONE;
               end else begin
                  r_d.last = 16'(stream_len(c == CMD_READ_DEFERRED ? r_q.defer_cmd : c) - 1);
                  r_d.st = ST_SEND;
               end
            end
         end
         ST_SEND: begin
            if (buf_in_ready) begin
               r_d.idx = r_q.idx + 16'h0001;
               if (r_q.idx == r_q.last) begin
                  r_d.st = ST_DONE;
               end
            end
         end
         ST_DONE: r_d.st = ST_IDLE;
         default: r_d.st = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
         r_q.rot[79:48] <= PULSE_WIDTH_RESET;
      end else begin
         r_q <= r_d;
      end
   end
   dsr_skid u_skid (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .in_valid_in(oct_valid),
      .in_data_in(oct),
      .in_ready_out(buf_in_ready),
      .out_valid_out(resp_valid_out),
      .out_data_out(resp_data_out),
      .out_ready_in(resp_ready_in)
   );
   sequence s_fmt_uninit;
      ctl_valid_in && ctl_ready_out && ctl_code_in == CMD_READ_FMT_PARAM && !format_init_in;
   endsequence
   sequence s_rej_status;
      status_valid_out && status_reject_out && status_context_out;
   endsequence
   AST_FMT_REJECT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      s_fmt_uninit |=> s_rej_status) else $error("uninitialized format not rejected");
   AST_DEFER_REJECT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ctl_valid_in && ctl_ready_out && ctl_code_in == CMD_READ_DEFERRED && !r_q.defer_pend
      |=> status_reject_out && status_context_out) else $error("no pending deferral accepted");
   AST_ROT_BUF_REJECT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ctl_valid_in && ctl_ready_out && ctl_code_in == CMD_READ_ROT_POS && buffer_only_in
      |=> status_reject_out) else $error("rotational readout in buffered mode");
   AST_REJ_NO_DATA: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      status_valid_out && status_reject_out |-> !$past(oct_valid))
      else $error("rejected control sent octets");
   AST_STEP_HEAD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ctl_valid_in && ctl_ready_out && ctl_code_in == DC_STEP_HEAD && !buffer_mode_in
      && !ctl_parity_err_in && !xfer_end_in |=> head_count_out == $past(head_count_out) + 16'h1)
      else $error("step head did not advance");
   AST_PARITY_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ctl_parity_err_in |=> head_count_out == $past(head_count_out))
      else $error("head advanced on parity error");
   AST_BUF_HEAD_REJECT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      ctl_valid_in && ctl_ready_out && buffer_mode_in && ctl_code_in == DC_STEP_HEAD
      |=> status_reject_out) else $error("step head accepted in buffer mode");
   AST_ADV_SIT: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      r_q.adv_pend && xfer_end_in && successful_transfer_flag_in && !ctl_parity_err_in
      && !ctl_valid_in |=> head_count_out == $past(head_count_out) + 16'h1)
      else $error("head not advanced on success");
   AST_IRQ_MASK: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
      r_q.por_seen && alt_allegiance_explicit_in && r_q.pc_exp == 8'h00 |-> !irq_enable_out)
      else $error("interrupt not suppressed");
endmodule : dsr_resp
`default_nettype wire

/* File: verif/dsr_host.sv */
// Master-side receiver of response octets, prompt or stalling
`default_nettype none
module dsr_host
   import dsr_pkg::*;
(
   // Clock
   input wire logic clk_sys_in,
   // Pacing chosen by the bench
   input wire logic slow_in,
   input wire logic hold_in,
   // Response stream acceptance
   output logic resp_ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] cnt_q = 2'h0;
   initial resp_ready_out = 1'b0;
   // Ready moves only off the sampling edge; slow accepts one cycle in four
   always @(negedge clk_sys_in) begin
      cnt_q <= cnt_q + 2'h1;
      resp_ready_out <= !hold_in && !(slow_in && cnt_q != 2'h0);
   end
endmodule : dsr_host
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the response-control handler
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench
   import dsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, rst_b_in = 1'b0, ctl_valid_in = 1'b0, ctl_parity_err_in = 1'b0;
   logic xfer_end_in = 1'b0, successful_transfer_flag_in = 1'b0, format_init_in = 1'b0;
   logic buffer_mode_in = 1'b0, buffer_only_in = 1'b0, data_ecc_en_in = 1'b1;
   logic header_ecc_en_in = 1'b0, defer_now_in = 1'b0, power_on_reset_in = 1'b0;
   logic alt_allegiance_explicit_in = 1'b0, alt_allegiance_implicit_in = 1'b0;
   logic port_ctl_load_in = 1'b0, rot_load_in = 1'b0, slow = 1'b0, hold = 1'b0;
   logic [7:0] ctl_code_in = 8'h00, port_ctl_explicit_in = 8'h00, port_ctl_implicit_in = 8'h00;
   logic [7:0] buf_flags_in = 8'h00;
   logic [15:0] ecc_octets_in = 16'h0000, pre_gap_in = 16'h0000, post_gap_in = 16'h0000;
   logic [1:0] cur_zone_in = 2'h0;
   logic [95:0] rot_param_in = 96'h0, rot_old;
   logic [8*BUF_PARAM_OCTETS-1:0] buf_param_in = 64'h0;
   logic [8*SLIP_OCTETS-1:0] slip_table_in = 128'h0;
   logic ctl_ready_out, resp_valid_out, resp_ready_in, status_valid_out, status_reject_out;
   logic status_context_out, status_deferred_out, irq_enable_out;
   logic [7:0] resp_data_out;
   logic [15:0] head_count_out, head_exp = 16'h0000;
   logic [8:0] oq[$], ov;
   logic [5:0] sq[$], sv;
   logic [31:0] rs = 32'hcb5d1c48;
   int error_cnt = 0, comparisons = 0, cyc = 0;
   dsr_resp dsr_resp_inst (.clk_sys_in, .rst_b_in, .ctl_valid_in, .ctl_code_in,
      .ctl_parity_err_in, .ctl_ready_out, .resp_valid_out, .resp_data_out, .resp_ready_in,
      .status_valid_out, .status_reject_out, .status_context_out, .status_deferred_out,
      .xfer_end_in, .successful_transfer_flag_in, .head_count_out, .format_init_in,
      .buffer_mode_in, .buffer_only_in, .data_ecc_en_in, .header_ecc_en_in, .ecc_octets_in,
      .cur_zone_in, .defer_now_in, .power_on_reset_in, .alt_allegiance_explicit_in,
      .alt_allegiance_implicit_in, .irq_enable_out, .port_ctl_load_in, .port_ctl_explicit_in,
      .port_ctl_implicit_in, .rot_load_in, .rot_param_in, .buf_flags_in, .buf_param_in,
      .slip_table_in, .pre_gap_in, .post_gap_in);
   dsr_host dsr_host_inst (.clk_sys_in, .slow_in(slow), .hold_in(hold),
      .resp_ready_out(resp_ready_in));
   always #12.5 clk_sys_in = ~clk_sys_in;
   function automatic logic [31:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : rnd
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end
   // Octet notes carry a do-not-care flag in bit 8; status notes a care mask over the bits
   always @(posedge clk_sys_in) begin
      if (resp_valid_out && resp_ready_in) begin
         `CHK(oq.size() > 0, 1'b1)
         ov = oq.size() > 0 ? oq.pop_front() : 9'h000;
         if (!ov[8]) `CHK(resp_data_out, ov[7:0])
      end
      if (status_valid_out) begin
         `CHK(sq.size() > 0, 1'b1)
         sv = sq.size() > 0 ? sq.pop_front() : 6'h00;
         `CHK({status_reject_out, status_context_out, status_deferred_out} & sv[5:3], sv[2:0])
      end
   end
   task automatic put(input logic [31:0] v, input int n, input logic dc = 1'b0);
      for (int i = n - 1; i >= 0; i--) oq.push_back({dc, v[8*i+:8]});
   endtask : put
   task automatic issue(input logic [7:0] code, input logic [5:0] st);
      int k;
      sq.push_back(st);
      @(negedge clk_sys_in);
      ctl_code_in = code;
      ctl_valid_in = 1'b1;
      k = 0;
      #1;
      while (!ctl_ready_out && k < 100) begin
         @(negedge clk_sys_in);
         #1;
         k++;
      end
      @(negedge clk_sys_in);
      ctl_valid_in = 1'b0;
      k = 0;
      while ((sq.size() > 0 || oq.size() > 0) && k < 800) begin
         @(negedge clk_sys_in);
         k++;
      end
      `CHK(k < 800, 1'b1)
      repeat (2) @(negedge clk_sys_in);
   endtask : issue
   task automatic pulse_end(input logic ok, input logic par);
      @(negedge clk_sys_in);
      xfer_end_in = 1'b1;
      successful_transfer_flag_in = ok;
      ctl_parity_err_in = par;
      @(negedge clk_sys_in);
      xfer_end_in = 1'b0;
      ctl_parity_err_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      `CHK(head_count_out, head_exp)
   endtask : pulse_end
   task automatic pulse(ref logic s);
      @(negedge clk_sys_in);
      s = 1'b1;
      @(negedge clk_sys_in);
      s = 1'b0;
   endtask : pulse
   initial begin
      repeat (16) @(negedge clk_sys_in);
      rst_b_in = 1'b1;
      pulse(power_on_reset_in);
      alt_allegiance_explicit_in = 1'b1;
      @(negedge clk_sys_in);
      `CHK(irq_enable_out, 1'b0)
      port_ctl_explicit_in = 8'(rnd()) | 8'h01;
      port_ctl_implicit_in = 8'(rnd());
      pulse(port_ctl_load_in);
      @(negedge clk_sys_in);
      `CHK(irq_enable_out, 1'b1)
      slow = 1'b1;
      put(port_ctl_explicit_in, 1);
      put(port_ctl_implicit_in, 1);
      issue(CMD_READ_PORT_CTL, 6'o70);
      pre_gap_in = 16'(rnd());
      post_gap_in = 16'(rnd());
      ecc_octets_in = 16'(rnd());
      buf_flags_in = 8'(rnd());
      buf_param_in = {rnd(), rnd()};
      slip_table_in = {rnd(), rnd(), rnd(), rnd()};
      issue(CMD_READ_FMT_PARAM, 6'o76);
      issue(CMD_READ_DEFERRED, 6'o76);
      issue(8'h7f, 6'o74);
      format_init_in = 1'b1;
      hold = 1'b1;
      put(16'd92, 2);
      put(ZONES, 2);
      put(FIELDS, 2);
      for (int z = 0; z < ZONES; z++) begin
         put(z, 2);
         put(z * 1000, 4);
         put(z * 1000 + 999, 4);
         for (int f = 0; f < FIELDS; f++) put({pre_gap_in, post_gap_in}, 4);
      end
      fork
         issue(CMD_READ_FMT_PARAM, 6'o70);
         begin
            repeat (30) @(negedge clk_sys_in);
            hold = 1'b0;
         end
      join
      // Data ECC only, header ECC only, then neither
      for (int e = 0; e < 3; e++) begin
         data_ecc_en_in = e == 0;
         header_ecc_en_in = e == 1;
         put(16'd96, 2);
         for (int i = 2; i < OFS_ECC_COUNT; i++) put(0, 1);
         put(e < 2 ? ecc_octets_in : 16'h0000, 2);
         put(ZONES, 2);
         for (int z = 0; z < ZONES; z++) begin
            put(z, 2);
            put(32'h2000 - 16 * z, 4);
         end
         issue(CMD_READ_DISK_SPEC, 6'o70);
      end
      for (int d = 0; d < 2; d++) begin
         defer_now_in = d == 1;
         put(16'(BUF_PARAM_OCTETS + 2), 2, d == 1);
         put({8'h00, buf_flags_in}, 2, d == 1);
         put(buf_param_in[63:32], 4, d == 1);
         put(buf_param_in[31:0], 4, d == 1);
         if (d == 0) issue(CMD_READ_BUF_CTL, 6'o70);
      end
      oq.delete();
      issue(CMD_READ_BUF_CTL, 6'o71);
      defer_now_in = 1'b0;
      put(16'(BUF_PARAM_OCTETS + 2), 2);
      put({8'h00, buf_flags_in}, 2);
      put(buf_param_in[63:32], 4);
      put(buf_param_in[31:0], 4);
      issue(CMD_READ_DEFERRED, 6'o70);
      defer_now_in = 1'b1;
      issue(CMD_READ_SLIP, 6'o71);
      defer_now_in = 1'b0;
      put({port_ctl_explicit_in, port_ctl_implicit_in}, 2);
      issue(CMD_READ_PORT_CTL, 6'o70);
      issue(CMD_READ_DEFERRED, 6'o76);
      put(SLIP_OCTETS, 2);
      for (int w = 3; w >= 0; w--) put(slip_table_in[32*w+:32], 4);
      issue(CMD_READ_SLIP, 6'o70);
      cur_zone_in = 2'(rnd());
      put(0, 2, 1'b1);
      put(32'h40 + 16 * cur_zone_in, 4);
      put(0, 4, 1'b1);
      put(0, 2, 1'b1);
      issue(CMD_READ_ROT_POS, 6'o70);
      rot_param_in = {rnd(), rnd(), rnd()};
      rot_old = rot_param_in;
      pulse(rot_load_in);
      for (int r = 0; r < 2; r++) begin
         cur_zone_in = cur_zone_in + 2'h1;
         put(rot_old[95:64], 4);
         put(rot_old[63:32], 4);
         put(rot_old[31:0], 4);
         issue(CMD_READ_ROT_POS, 6'o70);
         buffer_mode_in = r == 0;
         buffer_only_in = r == 1;
         issue(CMD_READ_ROT_POS, 6'o54);
         rot_param_in = {rnd(), rnd(), rnd()};
         pulse(rot_load_in);
         if (r == 1) rot_old = rot_param_in;
         buffer_mode_in = 1'b0;
         buffer_only_in = 1'b0;
      end
      slow = 1'b0;
      // Each field control precedes a handled field: one control per transfer end
      issue(8'h91, 6'o70);
      head_exp++;
      pulse_end(1'b1, 1'b0);
      issue(8'h91, 6'o70);
      pulse_end(1'b0, 1'b0);
      issue(8'h81, 6'o70);
      pulse_end(1'b1, 1'b0);
      issue(8'h91, 6'o70);
      pulse_end(1'b1, 1'b1);
      issue(DC_STEP_HEAD, 6'o70);
      head_exp++;
      `CHK(head_count_out, head_exp)
      ctl_parity_err_in = 1'b1;
      issue(DC_STEP_HEAD, 6'o00);
      ctl_parity_err_in = 1'b0;
      `CHK(head_count_out, head_exp)
      buffer_mode_in = 1'b1;
      issue(DC_STEP_HEAD, 6'o44);
      issue(8'h91, 6'o44);
      pulse_end(1'b1, 1'b0);
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
